// [verilog/dtc_pkg.sv]
package dtc_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NCH = 4;
  localparam int BUF_WORDS = 600;
  localparam int PCT_MAX = 100;
  // Sample period is programmed in units of 0.125 ms.
  localparam int UNIT_NS = 125000;
  localparam int CLK_NS = 4;
  localparam int TICK_CYC = UNIT_NS / CLK_NS;
  localparam logic [15:0] PERIOD_MIN = 16'h0001;
  localparam logic [15:0] PERIOD_MAX = 16'hfff8;
  localparam logic [15:0] PERIOD_RST = 16'h0010;
  localparam logic [7:0] A_CMD = 8'h00;
  localparam logic [7:0] A_CFG = 8'h04;
  localparam logic [7:0] A_LEVEL = 8'h08;
  localparam logic [7:0] A_PERIOD = 8'h0c;
  localparam logic [7:0] A_STATUS = 8'h10;
  localparam logic [7:0] A_CAPIDX = 8'h14;
  localparam logic [7:0] A_CAPDATA = 8'h18;
  localparam logic [7:0] A_PTRS = 8'h1c;
  localparam logic [7:0] A_LIVE0 = 8'h20;
  localparam int C_ARM = 0;
  localparam int C_FREE = 1;
  localparam int C_STOP = 2;
  localparam int C_UFAULT = 3;
  localparam int C_FRESET = 4;
  localparam int C_EN = 5;
  localparam int C_DIS = 6;
  localparam int C_MSTART = 7;
  localparam int C_MSTOP = 8;
  localparam int F_CONT = 2;
  localparam int F_TSEL = 4;
  localparam int F_MODE = 8;
  localparam int F_CHEN = 12;
  localparam int F_CHDBL = 16;
  localparam int F_POS = 24;
  localparam logic [31:0] CFG_RST = 32'h0000_1000;
  localparam logic [1:0] RESP_OK = 2'b00;
  localparam logic [1:0] RESP_ERR = 2'b10;
  typedef enum logic [1:0] {EDGE_IMM, EDGE_RISE, EDGE_FALL, EDGE_RSVD} dtc_edge_type;
  typedef enum logic [1:0] {SEV_NONE, SEV_WARN, SEV_DISABLE} dtc_sev_type;
  typedef enum logic [1:0] {MOT_VEL, MOT_CUR, MOT_TUNE, MOT_ALIGN} dtc_mot_type;
  typedef struct packed {
    logic awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic wvalid;
    logic [DATA_W-1:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [ADDR_W-1:0] araddr;
    logic rready;
  } dtc_axil_req_type;
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [DATA_W-1:0] rdata;
    logic [1:0] rresp;
  } dtc_axil_rsp_type;
endpackage

// [verilog/dtc_top.sv]
`timescale 1ns/1ps
module dtc_top #(
  parameter int TICK_CYCLES = dtc_pkg::TICK_CYC
) (
  input wire logic clock, // 250 MHz control clock.
  input wire logic resetn, // Asynchronous reset, active low.
  input wire dtc_pkg::dtc_axil_req_type axi_req, // AXI4-Lite master signals.
  output dtc_pkg::dtc_axil_rsp_type axi_rsp, // AXI4-Lite slave signals.
  input wire logic [3:0][31:0] chan_data, // Drive variables, same clock domain.
  input wire logic hw_enable, // Hardware enable pin.
  input wire logic warn_cause, // Warning cause pin.
  input wire logic fault_cause, // Disabling fault cause pin.
  output logic drive_enable, // Drive power stage enable.
  output logic motion_run, // Motion running.
  output logic [1:0] motion_mode // Motion type while running.
);
  if (TICK_CYCLES < 8) begin : g_chk
    $error("TICK_CYCLES must cover the eight-cycle store sequence");
  end

  typedef enum logic [2:0] {ST_IDLE, ST_FREE, ST_ARMED, ST_TRIGD, ST_DONE} dtc_state_type;

  localparam int TW = $clog2(TICK_CYCLES + 1);

  function automatic logic [31:0] strb_merge(input logic [31:0] old, input logic [31:0] nv,
                                             input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[i*8 +: 8] = nv[i*8 +: 8];
      end
    end
    return r;
  endfunction

  logic rst_s1_ff, rst_ff;
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rst_s1_ff <= 1'b0;
      rst_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_ff <= rst_s1_ff;
    end
  end
  wire logic rstn = rst_ff;

  logic [2:0] pin_s1_ff, pin_s2_ff;
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pin_s1_ff <= 3'h0;
      pin_s2_ff <= 3'h0;
    end else begin
      pin_s1_ff <= {fault_cause, warn_cause, hw_enable};
      pin_s2_ff <= pin_s1_ff;
    end
  end
  wire logic hw_en = pin_s2_ff[0];
  wire logic warn_c = pin_s2_ff[1];
  wire logic fault_c = pin_s2_ff[2];

  // Bus slave: one write and one read at a time, address and data in either order.
  logic aw_got_ff, w_got_ff, bvalid_ff, rvalid_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff, rdata_ff;
  logic [3:0] wstrb_ff;
  wire logic awready = !aw_got_ff && !bvalid_ff;
  wire logic wready = !w_got_ff && !bvalid_ff;
  wire logic arready = !rvalid_ff;
  wire logic aw_hs = axi_req.awvalid && awready;
  wire logic w_hs = axi_req.wvalid && wready;
  wire logic ar_hs = axi_req.arvalid && arready;
  wire logic do_wr = (aw_got_ff || aw_hs) && (w_got_ff || w_hs);
  wire logic [7:0] wa = aw_got_ff ? awaddr_ff : axi_req.awaddr;
  wire logic [31:0] wd = w_got_ff ? wdata_ff : axi_req.wdata;
  wire logic [3:0] ws = w_got_ff ? wstrb_ff : axi_req.wstrb;

  logic [31:0] cfg_ff, level_ff;
  logic [15:0] period_ff;
  logic [9:0] capidx_ff;
  wire logic [31:0] cfg_new = strb_merge(cfg_ff, wd, ws);
  wire logic [31:0] per_new = strb_merge({16'h0, period_ff}, wd, ws);
  wire logic pos_bad = cfg_new[dtc_pkg::F_POS +: 7] > 7'(dtc_pkg::PCT_MAX) || cfg_new[31];
  wire logic per_bad = per_new[15:0] < dtc_pkg::PERIOD_MIN
                       || per_new[15:0] > dtc_pkg::PERIOD_MAX || per_new[31:16] != 16'h0;
  wire logic wr_cmd = do_wr && wa == dtc_pkg::A_CMD;
  wire logic wr_cfg = do_wr && wa == dtc_pkg::A_CFG && !pos_bad;
  wire logic wr_lvl = do_wr && wa == dtc_pkg::A_LEVEL;
  wire logic wr_per = do_wr && wa == dtc_pkg::A_PERIOD && !per_bad;
  wire logic wr_idx = do_wr && wa == dtc_pkg::A_CAPIDX;
  wire logic wr_ok = wr_cmd || wr_cfg || wr_lvl || wr_per || wr_idx;
  wire logic [8:0] cmd = wr_cmd && ws[0] && ws[1] ? wd[8:0] : 9'h0;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= dtc_pkg::RESP_OK;
      awaddr_ff <= 8'h0;
      wdata_ff <= 32'h0;
      wstrb_ff <= 4'h0;
    end else begin
      aw_got_ff <= (aw_got_ff || aw_hs) && !do_wr;
      w_got_ff <= (w_got_ff || w_hs) && !do_wr;
      if (aw_hs) awaddr_ff <= axi_req.awaddr;
      if (w_hs) begin
        wdata_ff <= axi_req.wdata;
        wstrb_ff <= axi_req.wstrb;
      end
      if (do_wr) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_ok ? dtc_pkg::RESP_OK : dtc_pkg::RESP_ERR;
      end else if (axi_req.bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cfg_ff <= dtc_pkg::CFG_RST;
      level_ff <= 32'h0;
      period_ff <= dtc_pkg::PERIOD_RST;
      capidx_ff <= 10'h0;
    end else begin
      if (wr_cfg) cfg_ff <= cfg_new;
      if (wr_lvl) level_ff <= strb_merge(level_ff, wd, ws);
      if (wr_per) period_ff <= per_new[15:0];
      if (wr_idx) capidx_ff <= 10'(strb_merge({22'h0, capidx_ff}, wd, ws));
    end
  end

  wire dtc_pkg::dtc_edge_type edge_sel = dtc_pkg::dtc_edge_type'(cfg_ff[1:0]);
  wire logic cont = cfg_ff[dtc_pkg::F_CONT];
  wire logic [1:0] tsel = cfg_ff[dtc_pkg::F_TSEL +: 2];
  wire logic [3:0] ch_en = cfg_ff[dtc_pkg::F_CHEN +: 4];
  wire logic [3:0] ch_dbl = cfg_ff[dtc_pkg::F_CHDBL +: 4];
  wire logic [6:0] pos = cfg_ff[dtc_pkg::F_POS +: 7];

  // Drive status and control.
  logic sw_en_ff, ufault_ff, flatch_ff, motion_ff;
  logic [1:0] refuse_ff;
  wire logic disabling = flatch_ff || ufault_ff;
  wire dtc_pkg::dtc_sev_type sev = disabling ? dtc_pkg::SEV_DISABLE :
                                   warn_c ? dtc_pkg::SEV_WARN : dtc_pkg::SEV_NONE;
  wire logic en_req = cmd[dtc_pkg::C_EN] || cmd[dtc_pkg::C_MSTART];
  wire logic en_refuse = en_req && (!hw_en || disabling || cmd[dtc_pkg::C_UFAULT]);
  wire logic drive_on = hw_en && sw_en_ff && !disabling;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      sw_en_ff <= 1'b0;
      ufault_ff <= 1'b0;
      flatch_ff <= 1'b0;
      motion_ff <= 1'b0;
      refuse_ff <= 2'h0;
    end else begin
      // A cause or command in the reset cycle wins, so no fault slips past.
      ufault_ff <= cmd[dtc_pkg::C_UFAULT] || (ufault_ff && !cmd[dtc_pkg::C_FRESET]);
      flatch_ff <= fault_c || (flatch_ff && !cmd[dtc_pkg::C_FRESET]);
      if (en_refuse) begin
        refuse_ff <= {disabling || cmd[dtc_pkg::C_UFAULT], !hw_en};
      end else if (en_req) begin
        refuse_ff <= 2'h0;
      end
      if (!drive_on && !en_req) begin
        sw_en_ff <= 1'b0;
      end else if (cmd[dtc_pkg::C_DIS] || cmd[dtc_pkg::C_UFAULT] || en_refuse) begin
        sw_en_ff <= 1'b0;
      end else if (en_req) begin
        sw_en_ff <= 1'b1;
      end
      if (cmd[dtc_pkg::C_MSTOP] || cmd[dtc_pkg::C_DIS] || cmd[dtc_pkg::C_UFAULT] || en_refuse
          || (!drive_on && !en_req)) begin
        motion_ff <= 1'b0;
      end else if (cmd[dtc_pkg::C_MSTART]) begin
        motion_ff <= 1'b1;
      end
    end
  end

  // Capture sizing.
  logic [3:0] wps;
  always_comb begin
    wps = 4'h0;
    for (int i = 0; i < dtc_pkg::NCH; i++) begin
      wps = wps + {3'h0, ch_en[i]} + {3'h0, ch_en[i] && ch_dbl[i]};
    end
  end
  wire logic [9:0] entries = wps == 4'h0 ? 10'h0 : 10'(dtc_pkg::BUF_WORDS / int'(wps));
  wire logic [16:0] pre_prod = 17'(entries) * 17'(pos);
  wire logic [9:0] pre_calc = 10'(pre_prod / 17'(dtc_pkg::PCT_MAX));

  dtc_state_type state_ff;
  logic [9:0] pre_need_ff, post_need_ff, pre_cnt_ff, post_cnt_ff, cap_words_ff;
  logic [9:0] wptr_ff, trig_ptr_ff;
  logic [TW-1:0] base_ff;
  logic [15:0] unit_ff;
  logic tick_ff, prev_ok_ff, hit_ff, seq_ff;
  logic [2:0] widx_ff;
  logic signed [31:0] prev_ff;
  logic [3:0][31:0] snap_ff;
  logic [15:0] mem [dtc_pkg::BUF_WORDS];

  wire logic capturing = state_ff == ST_ARMED || state_ff == ST_TRIGD;
  wire logic arm_ok = cmd[dtc_pkg::C_ARM] && wps != 4'h0;
  wire logic signed [31:0] tval = signed'(chan_data[tsel]);
  wire logic signed [31:0] tlvl = signed'(level_ff);
  wire logic rise_hit = tval > prev_ff && tval >= tlvl;
  wire logic fall_hit = tval < prev_ff && tval <= tlvl;
  wire logic edge_hit = prev_ok_ff && (edge_sel == dtc_pkg::EDGE_RISE ? rise_hit :
                                       edge_sel == dtc_pkg::EDGE_FALL && fall_hit);
  wire logic tick_now = capturing && tick_ff && !seq_ff;
  wire logic [1:0] wch = widx_ff[2:1];
  wire logic wr_word = seq_ff && ch_en[wch] && (!widx_ff[0] || ch_dbl[wch]);
  wire logic ent_end = seq_ff && widx_ff == 3'h7;
  wire logic pre_full = pre_cnt_ff >= pre_need_ff;
  wire logic trig_now = state_ff == ST_ARMED && ent_end && pre_full
                        && (edge_sel == dtc_pkg::EDGE_IMM || hit_ff);
  wire logic post_last = post_cnt_ff + 10'h1 >= post_need_ff;
  wire logic [9:0] wptr_inc = wptr_ff + 10'h1 >= cap_words_ff ? 10'h0 : wptr_ff + 10'h1;
  wire logic [9:0] wptr_next = wr_word ? wptr_inc : wptr_ff;
  wire logic [9:0] ent_base = (wptr_next == 10'h0 ? cap_words_ff : wptr_next) - {6'h0, wps};

  // Sample period timer, restarted by arming so the first sample follows a full period.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      base_ff <= '0;
      unit_ff <= 16'h0;
      tick_ff <= 1'b0;
    end else if (arm_ok || !capturing) begin
      base_ff <= '0;
      unit_ff <= 16'h0;
      tick_ff <= 1'b0;
    end else begin
      tick_ff <= 1'b0;
      if (base_ff == TW'(TICK_CYCLES - 1)) begin
        base_ff <= '0;
        if (unit_ff + 16'h1 >= period_ff) begin
          unit_ff <= 16'h0;
          tick_ff <= 1'b1;
        end else begin
          unit_ff <= unit_ff + 16'h1;
        end
      end else begin
        base_ff <= base_ff + TW'(1);
      end
    end
  end

  // Each sample is stored one word per clock; the period is never shorter than eight clocks.
  always_ff @(posedge clock) begin
    if (wr_word) mem[wptr_ff] <= widx_ff[0] ? snap_ff[wch][31:16] : snap_ff[wch][15:0];
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_ff <= ST_IDLE;
      pre_need_ff <= 10'h0;
      post_need_ff <= 10'h0;
      pre_cnt_ff <= 10'h0;
      post_cnt_ff <= 10'h0;
      cap_words_ff <= 10'h0;
      wptr_ff <= 10'h0;
      trig_ptr_ff <= 10'h0;
      prev_ok_ff <= 1'b0;
      prev_ff <= 32'sh0;
      hit_ff <= 1'b0;
      seq_ff <= 1'b0;
      widx_ff <= 3'h0;
      snap_ff <= '0;
    end else if (cmd[dtc_pkg::C_STOP]) begin
      state_ff <= ST_IDLE;
      seq_ff <= 1'b0;
      widx_ff <= 3'h0;
    end else if (arm_ok || (state_ff == ST_DONE && cont)) begin
      state_ff <= ST_ARMED;
      pre_need_ff <= pre_calc;
      post_need_ff <= entries - pre_calc;
      cap_words_ff <= 10'(entries * wps);
      pre_cnt_ff <= 10'h0;
      post_cnt_ff <= 10'h0;
      wptr_ff <= 10'h0;
      prev_ok_ff <= 1'b0;
      seq_ff <= 1'b0;
      widx_ff <= 3'h0;
    end else if (cmd[dtc_pkg::C_FREE]) begin
      state_ff <= ST_FREE;
      seq_ff <= 1'b0;
    end else begin
      if (tick_now) begin
        snap_ff <= chan_data;
        hit_ff <= edge_hit;
        prev_ff <= tval;
        prev_ok_ff <= 1'b1;
        seq_ff <= 1'b1;
        widx_ff <= 3'h0;
      end else if (seq_ff) begin
        widx_ff <= widx_ff + 3'h1;
        seq_ff <= widx_ff != 3'h7;
      end
      if (wr_word) wptr_ff <= wptr_inc;
      if (ent_end) begin
        if (trig_now) begin
          trig_ptr_ff <= ent_base;
          post_cnt_ff <= 10'h1;
          state_ff <= post_need_ff <= 10'h1 ? ST_DONE : ST_TRIGD;
        end else if (state_ff == ST_ARMED && !pre_full) begin
          pre_cnt_ff <= pre_cnt_ff + 10'h1;
        end else if (state_ff == ST_TRIGD) begin
          post_cnt_ff <= post_cnt_ff + 10'h1;
          if (post_last) state_ff <= ST_DONE;
        end
      end
    end
  end

  // Read side.
  wire logic [7:0] ra = axi_req.araddr;
  wire logic live_hit = ra[7:4] == dtc_pkg::A_LIVE0[7:4] && ra[1:0] == 2'h0;
  logic [31:0] rd_mux;
  logic rd_ok;
  always_comb begin
    rd_ok = 1'b1;
    rd_mux = 32'h0;
    if (ra == dtc_pkg::A_CMD) rd_mux = 32'h0;
    else if (ra == dtc_pkg::A_CFG) rd_mux = cfg_ff;
    else if (ra == dtc_pkg::A_LEVEL) rd_mux = level_ff;
    else if (ra == dtc_pkg::A_PERIOD) rd_mux = {16'h0, period_ff};
    else if (ra == dtc_pkg::A_STATUS) rd_mux = {20'h0, refuse_ff, motion_ff, drive_on,
                                                2'h0, sev, 1'b0, state_ff};
    else if (ra == dtc_pkg::A_CAPIDX) rd_mux = {22'h0, capidx_ff};
    else if (ra == dtc_pkg::A_CAPDATA) rd_mux = {16'h0, capidx_ff < 10'(dtc_pkg::BUF_WORDS) ?
                                                 mem[capidx_ff] : 16'h0};
    else if (ra == dtc_pkg::A_PTRS) rd_mux = {6'h0, trig_ptr_ff, 6'h0, wptr_next};
    else if (live_hit) rd_mux = state_ff == ST_FREE ? chan_data[ra[3:2]] : 32'h0;
    else rd_ok = 1'b0;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0;
      rresp_ff <= dtc_pkg::RESP_OK;
    end else if (ar_hs) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_mux;
      rresp_ff <= rd_ok ? dtc_pkg::RESP_OK : dtc_pkg::RESP_ERR;
    end else if (axi_req.rready) begin
      rvalid_ff <= 1'b0;
    end
  end

  always_comb begin
    axi_rsp.awready = awready;
    axi_rsp.wready = wready;
    axi_rsp.bvalid = bvalid_ff;
    axi_rsp.bresp = bresp_ff;
    axi_rsp.arready = arready;
    axi_rsp.rvalid = rvalid_ff;
    axi_rsp.rdata = rdata_ff;
    axi_rsp.rresp = rresp_ff;
  end
  assign drive_enable = drive_on;
  assign motion_run = motion_ff && drive_on;
  assign motion_mode = cfg_ff[dtc_pkg::F_MODE +: 2];

  property p_stop;
    @(posedge clock) disable iff (!rstn) cmd[dtc_pkg::C_STOP] |=> state_ff == ST_IDLE;
  endproperty
  a_stop: assert property (p_stop) else $error("stop did not return to idle");
  property p_imm;
    @(posedge clock) disable iff (!rstn)
      state_ff == ST_ARMED && ent_end && pre_full && edge_sel == dtc_pkg::EDGE_IMM
      && !cmd[dtc_pkg::C_STOP] && !arm_ok && !cmd[dtc_pkg::C_FREE]
      |=> state_ff inside {ST_TRIGD, ST_DONE};
  endproperty
  a_imm: assert property (p_imm) else $error("immediate trigger missed");
  property p_edge;
    @(posedge clock) disable iff (!rstn)
      trig_now && edge_sel != dtc_pkg::EDGE_IMM |-> hit_ff && prev_ok_ff;
  endproperty
  a_edge: assert property (p_edge) else $error("edge trigger without qualifying sample");
  property p_cont;
    @(posedge clock) disable iff (!rstn)
      state_ff == ST_DONE && cont && !cmd[dtc_pkg::C_STOP] |=> state_ff == ST_ARMED;
  endproperty
  a_cont: assert property (p_cont) else $error("continuous mode did not re-arm");
  property p_single;
    @(posedge clock) disable iff (!rstn)
      state_ff == ST_DONE && !cont && !cmd[dtc_pkg::C_ARM] && !cmd[dtc_pkg::C_STOP]
      && !cmd[dtc_pkg::C_FREE]
      |=> state_ff == ST_DONE;
  endproperty
  a_single: assert property (p_single) else $error("single capture left complete state");
  property p_pos;
    @(posedge clock) disable iff (!rstn)
      pos <= 7'(dtc_pkg::PCT_MAX) && pre_need_ff <= cap_words_ff;
  endproperty
  a_pos: assert property (p_pos) else $error("trigger position out of range");
  property p_sev;
    @(posedge clock) disable iff (!rstn)
      (fault_c |=> sev == dtc_pkg::SEV_DISABLE && !drive_enable);
  endproperty
  a_sev: assert property (p_sev) else $error("fault not reported as disabling");
  property p_ufault;
    @(posedge clock) disable iff (!rstn)
      cmd[dtc_pkg::C_UFAULT] |=> !drive_enable && !motion_run ##1 !drive_enable;
  endproperty
  a_ufault: assert property (p_ufault) else $error("user fault did not disable");
  property p_refuse;
    @(posedge clock) disable iff (!rstn) en_req && !hw_en |=> refuse_ff[0] && !sw_en_ff;
  endproperty
  a_refuse: assert property (p_refuse) else $error("enable without hardware enable");
endmodule

// [verification/dtc_host_model.sv]
`timescale 1ns/1ps
module dtc_host_model (
  input wire logic clock, // Bus clock.
  output dtc_pkg::dtc_axil_req_type req, // Master side of the register bus.
  input wire dtc_pkg::dtc_axil_rsp_type rsp // Slave answers.
);
  initial req = '0;
  // Address and data are offered together and each is dropped at its own handshake.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_left;
    logic w_left;
    aw_left = 1'b1;
    w_left = 1'b1;
    @(posedge clock);
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hf;
    req.bready <= 1'b1;
    do begin
      @(posedge clock);
      if (aw_left && rsp.awready) begin
        aw_left = 1'b0;
        req.awvalid <= 1'b0;
      end
      if (w_left && rsp.wready) begin
        w_left = 1'b0;
        req.wvalid <= 1'b0;
      end
    end while (aw_left || w_left || !rsp.bvalid);
    r = rsp.bresp;
    req.bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_left;
    ar_left = 1'b1;
    @(posedge clock);
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    do begin
      @(posedge clock);
      if (ar_left && rsp.arready) begin
        ar_left = 1'b0;
        req.arvalid <= 1'b0;
      end
    end while (ar_left || !rsp.rvalid);
    d = rsp.rdata;
    r = rsp.rresp;
    req.rready <= 1'b0;
  endtask
endmodule

// [verification/drive_trace_trigger_capture_tb_top.sv]
`timescale 1ns/1ps
module drive_trace_trigger_capture_tb_top;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  dtc_pkg::dtc_axil_req_type axi_req;
  dtc_pkg::dtc_axil_rsp_type axi_rsp;
  logic [3:0][31:0] chan_data = '0;
  logic hw_en = 1'b0;
  logic warn = 1'b0;
  logic flt = 1'b0;
  logic en_o;
  logic run_o;
  logic [1:0] mode_o;
  int n_errors = 0;
  int comparisons = 0;
  int cyc = 0;
  int dir = 0;
  int trig;
  int seed;
  logic [1:0] resp;
  logic [31:0] rd;
  logic [31:0] lvl;
  always #2 clock = ~clock;
  dtc_top #(.TICK_CYCLES(16)) uut (.clock(clock), .resetn(resetn), .axi_req(axi_req),
    .axi_rsp(axi_rsp), .chan_data(chan_data), .hw_enable(hw_en), .warn_cause(warn),
    .fault_cause(flt), .drive_enable(en_o), .motion_run(run_o), .motion_mode(mode_o));
  dtc_host_model host (.clock(clock), .req(axi_req), .rsp(axi_rsp));
  // A ramp on channel 0 gives edge triggers a known crossing point.
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (dir != 0) begin
      chan_data[0] <= chan_data[0] + 32'(dir);
    end
    if (cyc == 95000) begin
      n_errors++;
      final_report();
    end
  end
  task automatic final_report();
    $display("errors=%0d comparisons=%0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic w(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    host.wr(a, d, resp);
    chk(32'(resp), 32'(e));
  endtask
  task automatic get(input logic [7:0] a);
    host.rd(a, rd, resp);
  endtask
  task automatic r(input logic [7:0] a, input logic [31:0] e);
    get(a);
    chk(rd, e);
  endtask
  task automatic cmd(input int b);
    w(dtc_pkg::A_CMD, 32'h1 << b, dtc_pkg::RESP_OK);
  endtask
  task automatic stf(input int lo, input logic [3:0] e);
    get(dtc_pkg::A_STATUS);
    chk(32'(rd[lo+:4]), 32'(e));
  endtask
  // Pins pass a two-stage synchroniser, so a few clocks are allowed before looking.
  task automatic pins(input logic h, input logic wn, input logic f);
    hw_en <= h;
    warn <= wn;
    flt <= f;
    repeat (5) @(posedge clock);
  endtask
  task automatic poll(input logic [2:0] s);
    int i;
    i = 0;
    get(dtc_pkg::A_STATUS);
    while (rd[2:0] != s && i < 1000) begin
      repeat (16) @(posedge clock);
      get(dtc_pkg::A_STATUS);
      i++;
    end
  endtask
  task automatic cap(input logic [1:0] edg, input int wps, input int pct, input int d);
    int pre;
    pre = (600 / wps) * pct / 100;
    w(dtc_pkg::A_CFG, 32'(edg) | 32'(wps - 1) << 16 | 32'(pct) << 24 | 32'h1000, 2'b00);
    cmd(dtc_pkg::C_ARM);
    dir <= d;
    stf(0, 4'h2);
    poll(3'h4);
    chk(32'(rd[2:0]), 32'h4);
    dir <= 0;
    get(dtc_pkg::A_PTRS);
    trig = int'(rd[25:16]);
    chk(32'(rd[9:0]), 32'((trig + (600 / wps - pre) * wps) % 600));
    if (edg == 2'b00) begin
      chk(32'(trig), 32'((pre * wps) % 600));
    end
    repeat (40) @(posedge clock);
    stf(0, 4'h4);
  endtask
  task automatic edge_test(input logic up);
    logic [31:0] v0;
    v0 = up ? 32'd1000 : 32'd60000;
    lvl = up ? v0 + 2000 + $urandom % 1000 : v0 - 2000 - $urandom % 1000;
    chan_data[0] <= v0;
    w(dtc_pkg::A_LEVEL, lvl, 2'b00);
    cap(up ? 2'b01 : 2'b10, 1, 10, up ? 1 : -1);
    w(dtc_pkg::A_CAPIDX, 32'(trig), 2'b00);
    get(dtc_pkg::A_CAPDATA);
    chk(32'(up ? rd >= lvl : rd <= lvl), 32'h1);
    w(dtc_pkg::A_CAPIDX, 32'((trig + 599) % 600), 2'b00);
    get(dtc_pkg::A_CAPDATA);
    chk(32'(up ? rd < lvl : rd > lvl), 32'h1);
  endtask
  initial begin
    seed = $urandom(37093);
    chan_data = {$urandom, $urandom, $urandom, $urandom};
    repeat (10) @(posedge clock);
    resetn <= 1'b1;
    repeat (4) @(posedge clock);
    r(dtc_pkg::A_CFG, dtc_pkg::CFG_RST);
    r(dtc_pkg::A_PERIOD, 32'(dtc_pkg::PERIOD_RST));
    r(dtc_pkg::A_STATUS, 32'h0);
    get(8'h40);
    chk(32'(resp), 32'(dtc_pkg::RESP_ERR));
    w(dtc_pkg::A_CFG, 32'h6500_1000, dtc_pkg::RESP_ERR);
    w(dtc_pkg::A_CFG, 32'h6400_1000, dtc_pkg::RESP_OK);
    r(dtc_pkg::A_CFG, 32'h6400_1000);
    w(dtc_pkg::A_PERIOD, 32'h0, dtc_pkg::RESP_ERR);
    w(dtc_pkg::A_PERIOD, 32'hfff9, dtc_pkg::RESP_ERR);
    w(dtc_pkg::A_PERIOD, 32'(dtc_pkg::PERIOD_MAX), dtc_pkg::RESP_OK);
    w(dtc_pkg::A_PERIOD, 32'h1, dtc_pkg::RESP_OK);
    cmd(dtc_pkg::C_EN);
    stf(8, 4'h4);
    pins(1'b1, 1'b0, 1'b0);
    chk(32'(en_o), 32'h0);
    cmd(dtc_pkg::C_EN);
    chk(32'(en_o), 32'h1);
    for (int m = 0; m < 4; m++) begin
      w(dtc_pkg::A_CFG, 32'h1000 | 32'(m) << 8, dtc_pkg::RESP_OK);
      cmd(dtc_pkg::C_MSTART);
      chk(32'({run_o, mode_o}), 32'(4 + m));
      cmd(dtc_pkg::C_MSTOP);
      chk(32'(run_o), 32'h0);
    end
    pins(1'b1, 1'b1, 1'b0);
    stf(4, 4'h1);
    pins(1'b1, 1'b1, 1'b1);
    stf(4, 4'h2);
    chk(32'(en_o), 32'h0);
    cmd(dtc_pkg::C_FRESET);
    stf(4, 4'h2);
    cmd(dtc_pkg::C_EN);
    stf(8, 4'h8);
    pins(1'b1, 1'b1, 1'b0);
    cmd(dtc_pkg::C_FRESET);
    stf(4, 4'h1);
    pins(1'b1, 1'b0, 1'b0);
    cmd(dtc_pkg::C_EN);
    cmd(dtc_pkg::C_UFAULT);
    chk(32'(en_o), 32'h0);
    stf(4, 4'h2);
    cmd(dtc_pkg::C_FRESET);
    stf(4, 4'h0);
    cmd(dtc_pkg::C_FREE);
    stf(0, 4'h1);
    for (int i = 0; i < 4; i++) begin
      r(dtc_pkg::A_LIVE0 + 8'(4 * i), chan_data[i]);
    end
    cmd(dtc_pkg::C_STOP);
    stf(0, 4'h0);
    r(dtc_pkg::A_LIVE0, 32'h0);
    cap(2'b00, 1, 0, 0);
    cap(2'b00, 2, 50, 0);
    cap(2'b00, 1, 1 + $urandom % 99, 0);
    edge_test(1'b1);
    edge_test(1'b0);
    w(dtc_pkg::A_CFG, 32'h0000_1004, dtc_pkg::RESP_OK);
    cmd(dtc_pkg::C_ARM);
    poll(3'h3);
    chk(32'(rd[2:0]), 32'h3);
    repeat (9800) @(posedge clock);
    get(dtc_pkg::A_STATUS);
    chk(32'(rd[2:0] == 3'h2 || rd[2:0] == 3'h3), 32'h1);
    cmd(dtc_pkg::C_STOP);
    stf(0, 4'h0);
    final_report();
  end
endmodule
